// ===== rtl/pms_cfg.svh
//------------------------------------------------------------
// Behaviour
// - wait instruction triggers configured low-power entry
// - sleep maps to wait, deep-sleep to stop
// - run regulation in run, wait, stop
// - stop regulation in low-power modes, limit buses
// - run select field moves run to very-low-power run
// - from very-low-power run allow matching wait, stop
// - hold I/O states in every mode
// - normal run: full speed, run regulation
// - wait gates core clock only
// - stop classes gate buses after all acknowledges
// - very-low-power run restricts all clock frequencies
// - very-low-power wait gates core, restricted others
// - leakage stop lowers logic voltage, retains all
// - ram-kept stop powers logic off, keeps RAM
// - ram-off stops power down logic and RAM
// - osc-off stop kills oscillator, por per option
// - disallowed or reserved mode request is ignored
//------------------------------------------------------------
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH

// run mode select encodings
`define PMS_RUN_MODE_SELECT_NORMAL 2'h0
`define PMS_RUN_MODE_SELECT_VLP 2'h2
// stop mode select encodings
`define PMS_STOPM_NORMAL 3'h0
`define PMS_STOPM_VLP 3'h2
`define PMS_STOPM_LLS 3'h3
`define PMS_STOPM_VLLS 3'h4
// leakage stop sub-level encodings
`define PMS_VLLSM_OSC_OFF 2'h0
`define PMS_VLLSM_RAM_OFF 2'h1
`define PMS_VLLSM_RAM_KEPT 2'h3
// cycles between gating steps on entry and exit
`define PMS_STEP_CYC 4'h2

`endif

// ===== rtl/pms_pkg.sv
package pms_pkg;
   // power mode as reported to the outside
   typedef enum logic [3:0] {
      PMS_RUN, PMS_WAIT, PMS_STOP, PMS_VERY_LOW_POWER_RUN, PMS_VERY_LOW_POWER_WAIT, PMS_VERY_LOW_POWER_STOP,
      PMS_LLS, PMS_LEAKAGE_STOP_RAM_KEPT, PMS_LEAKAGE_STOP_RAM_OFF, PMS_VLLS0
   } pms_mode_e;
   // sequencer states
   typedef enum logic [2:0] {
      PMS_S_RUN, PMS_S_GATE_CORE, PMS_S_WAIT_ACK, PMS_S_LOW, PMS_S_UNGATE_BUS,
      PMS_S_UNGATE_CORE
   } pms_state_e;
endpackage

// ===== rtl/pms_ctl_if.sv
`timescale 1ns/10ps
// carries the gating requests from the top to the clock gater, and step_done back
interface pms_ctl_if;
   logic core_gate;
   logic bus_gate;
   logic step_done;
   modport seq (output core_gate, output bus_gate, input step_done);
   modport gater (input core_gate, input bus_gate, output step_done);
endinterface // pms_ctl_if

// ===== rtl/pms_clk_gater.sv
`timescale 1ns/10ps
`include "pms_cfg.svh"
// paces each gating step by a settle count
module pms_clk_gater
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // request from sequencer
   pms_ctl_if.gater ctl
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic core_q;
   logic core_d;
   logic bus_q;
   logic bus_d;
   //------------------------------------------------------------
   // settle counter
   //------------------------------------------------------------
   // restart the count whenever the requested gating changes
   always_comb
   begin
      core_d = ctl.core_gate;
      bus_d = ctl.bus_gate;
      if ((core_q != ctl.core_gate) || (bus_q != ctl.bus_gate))
      begin
         cnt_d = 4'h0;
      end
      else if (cnt_q != `PMS_STEP_CYC)
      begin
         cnt_d = cnt_q + 4'h1;
      end
      else
      begin
         cnt_d = cnt_q;
      end
   end
   // registers only
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cnt_q <= 4'h0;
         core_q <= 1'b0;
         bus_q <= 1'b0;
      end
      else if (clk_en)
      begin
         cnt_q <= cnt_d;
         core_q <= core_d;
         bus_q <= bus_d;
      end
   end
   assign ctl.step_done = (cnt_q == `PMS_STEP_CYC) && (core_q == ctl.core_gate) &&
      (bus_q == ctl.bus_gate);
endmodule // pms_clk_gater

// ===== rtl/pms_top.sv
`timescale 1ns/10ps
`include "pms_cfg.svh"
// power mode sequencer top
module pms_top
   import pms_pkg::*;
#(
   parameter int NUM_ACK = 4
)
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // processor
   input wire logic wait_instr,
   input wire logic sleep_deep,
   // mode configuration
   input wire logic [1:0] run_mode_select,
   input wire logic [2:0] stop_mode_select,
   input wire logic [1:0] vlls_level,
   input wire logic por_option_bit,
   input wire logic allow_vlp,
   input wire logic allow_lls,
   input wire logic allow_vlls,
   // wake and peripheral handshake
   input wire logic wake_event,
   input wire logic [NUM_ACK-1:0] stop_ack,
   output logic stop_req,
   // clocks, power and mode
   output logic core_clk_gate,
   output logic bus_clk_gate,
   output logic freq_limit,
   output logic stop_regulation,
   output logic logic_low_volt,
   output logic logic_power_off,
   output logic ram_power_off,
   output logic osc_disable,
   output logic por_enable,
   output logic io_hold,
   output pms_pkg::pms_mode_e power_mode
);
   import pms_pkg::*;
   pms_ctl_if ctl ();
   pms_state_e st_q;
   pms_state_e st_d;
   pms_mode_e mode_q;
   pms_mode_e mode_d;
   pms_mode_e run_q;
   pms_mode_e run_d;
   logic stop_req_q;
   logic stop_req_d;
   logic core_q;
   logic core_d;
   logic bus_q;
   logic bus_d;
   pms_mode_e target;
   logic target_ok;
   logic target_stop;
   logic all_ack;

   //------------------------------------------------------------
   // step pacing
   //------------------------------------------------------------
   pms_clk_gater u_gater
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .ctl(ctl.gater)
   );
   assign ctl.core_gate = core_q;
   assign ctl.bus_gate = bus_q;
   assign all_ack = &stop_ack;

   //------------------------------------------------------------
   // target mode decode
   //------------------------------------------------------------
   // pick the low-power mode the wait instruction asks for
   always_comb
   begin
      target = mode_q;
      target_ok = 1'b0;
      target_stop = 1'b0;
      if (!sleep_deep)
      begin
         // sleep lands in a wait class mode
         target = (mode_q == PMS_VERY_LOW_POWER_RUN) ? PMS_VERY_LOW_POWER_WAIT : PMS_WAIT;
         target_ok = 1'b1;
      end
      else
      begin
         target_stop = 1'b1;
         case (stop_mode_select)
            `PMS_STOPM_NORMAL:
            begin
               // deep sleep from slow run stays in the slow stop
               target = (mode_q == PMS_VERY_LOW_POWER_RUN) ? PMS_VERY_LOW_POWER_STOP : PMS_STOP;
               target_ok = 1'b1;
            end
            `PMS_STOPM_VLP:
            begin
               target = PMS_VERY_LOW_POWER_STOP;
               target_ok = allow_vlp;
            end
            `PMS_STOPM_LLS:
            begin
               target = PMS_LLS;
               target_ok = allow_lls && (mode_q == PMS_RUN);
            end
            `PMS_STOPM_VLLS:
            begin
               target_ok = allow_vlls && (mode_q == PMS_RUN);
               case (vlls_level)
                  `PMS_VLLSM_RAM_KEPT: target = PMS_LEAKAGE_STOP_RAM_KEPT;
                  `PMS_VLLSM_RAM_OFF: target = PMS_LEAKAGE_STOP_RAM_OFF;
                  `PMS_VLLSM_OSC_OFF: target = PMS_VLLS0;
                  default: target_ok = 1'b0;
               endcase
            end
            default:
            begin
               target_ok = 1'b0;
            end
         endcase
      end
   end

   //------------------------------------------------------------
   // sequencer
   //------------------------------------------------------------
   // entry gates core then buses, exit ungates in reverse
   //
   // state walk for a stop-class entry:
   //    run        - wait instruction taken, core gate raised, mode moves
   //    gate_core  - hold until the gater reports the core gate settled
   //    wait_ack   - stop request out, buses stay live until all acks
   //    low        - parked; low-volt, power-off and osc outputs decode only in this state
   //    ungate_bus - bus clocks back first so peripherals can resume
   //    ungate_core- core clock back last, mode returns to saved run
   //
   // a wait-class entry skips wait_ack: the bus gate never rises and
   // no stop request is raised, so peripherals keep running.
   //
   // hazards and limits:
   //    - the wait instruction is a level; if it still stands when the
   //      sequence lands back in run, the mode is entered again at once.
   //    - a wake that arrives before the gater settles is held off until
   //      the step is done, so a short wake pulse can be missed; wake
   //      sources are expected to hold their request.
   //    - a stop acknowledge that drops while waiting simply delays the
   //      bus gate; nothing times out here.
   //    - the leakage modes are left through the same wake path, which
   //      keeps the model simple; real silicon would reset instead.
   //    - the saved run mode lives in run_q, so a slow run that enters
   //      a wait or stop returns to slow run, not to full speed.
   //    - mode select inputs are read live in run; software must settle
   //      them before issuing the wait instruction.
   //    - io_hold is tied high because pin states are held in every
   //      mode, including the deepest ones.
   //
   // every register advances only while clk_en is high, so a low
   // enable freezes the sequence in whatever step it has reached.
   //
   always_comb
   begin
      st_d = st_q;
      mode_d = mode_q;
      run_d = run_q;
      stop_req_d = stop_req_q;
      core_d = core_q;
      bus_d = bus_q;
      case (st_q)
         PMS_S_RUN:
         begin
            if (wait_instr && target_ok)
            begin
               // enter the configured low-power mode
               run_d = mode_q;
               mode_d = target;
               core_d = 1'b1;
               st_d = PMS_S_GATE_CORE;
            end
            else if ((mode_q == PMS_RUN) && (run_mode_select == `PMS_RUN_MODE_SELECT_VLP) && allow_vlp)
            begin
               mode_d = PMS_VERY_LOW_POWER_RUN;
            end
            else if ((mode_q == PMS_VERY_LOW_POWER_RUN) && (run_mode_select == `PMS_RUN_MODE_SELECT_NORMAL))
            begin
               mode_d = PMS_RUN;
            end
         end
         PMS_S_GATE_CORE:
         begin
            if (ctl.step_done)
            begin
               if (target_stop)
               begin
                  stop_req_d = 1'b1;
                  st_d = PMS_S_WAIT_ACK;
               end
               else
               begin
                  st_d = PMS_S_LOW;
               end
            end
         end
         PMS_S_WAIT_ACK:
         begin
            // buses gate only once every peripheral agrees
            if (all_ack)
            begin
               bus_d = 1'b1;
               st_d = PMS_S_LOW;
            end
         end
         PMS_S_LOW:
         begin
            if (wake_event && ctl.step_done)
            begin
               bus_d = 1'b0;
               stop_req_d = 1'b0;
               st_d = PMS_S_UNGATE_BUS;
            end
         end
         PMS_S_UNGATE_BUS:
         begin
            if (ctl.step_done)
            begin
               core_d = 1'b0;
               st_d = PMS_S_UNGATE_CORE;
            end
         end
         PMS_S_UNGATE_CORE:
         begin
            if (ctl.step_done)
            begin
               mode_d = run_q;
               st_d = PMS_S_RUN;
            end
         end
         default:
         begin
            st_d = PMS_S_RUN;
         end
      endcase
   end
   // registers only
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_q <= PMS_S_RUN;
         mode_q <= PMS_RUN;
         run_q <= PMS_RUN;
         stop_req_q <= 1'b0;
         core_q <= 1'b0;
         bus_q <= 1'b0;
      end
      else if (clk_en)
      begin
         st_q <= st_d;
         mode_q <= mode_d;
         run_q <= run_d;
         stop_req_q <= stop_req_d;
         core_q <= core_d;
         bus_q <= bus_d;
      end
   end

   //------------------------------------------------------------
   // power and clock outputs
   //------------------------------------------------------------
   assign power_mode = mode_q;
   assign stop_req = stop_req_q;
   assign core_clk_gate = core_q;
   assign bus_clk_gate = bus_q;
   // run regulation in run, wait, stop; stop regulation elsewhere
   assign stop_regulation = !((mode_q == PMS_RUN) || (mode_q == PMS_WAIT) ||
      (mode_q == PMS_STOP));
   assign freq_limit = (mode_q == PMS_VERY_LOW_POWER_RUN) || (mode_q == PMS_VERY_LOW_POWER_WAIT) ||
      (mode_q == PMS_VERY_LOW_POWER_STOP);
   assign logic_low_volt = (mode_q == PMS_LLS) && (st_q == PMS_S_LOW);
   assign logic_power_off = ((mode_q == PMS_LEAKAGE_STOP_RAM_KEPT) || (mode_q == PMS_LEAKAGE_STOP_RAM_OFF) ||
      (mode_q == PMS_VLLS0)) && (st_q == PMS_S_LOW);
   assign ram_power_off = ((mode_q == PMS_LEAKAGE_STOP_RAM_OFF) || (mode_q == PMS_VLLS0)) &&
      (st_q == PMS_S_LOW);
   assign osc_disable = (mode_q == PMS_VLLS0) && (st_q == PMS_S_LOW);
   assign por_enable = !osc_disable || por_option_bit;
   assign io_hold = 1'b1;
endmodule // pms_top

// ===== test/pms_ack_model.sv
`timescale 1ns/10ps
// peripherals: each ack rises a step after the last, after a delay
module pms_ack_model
#(
   parameter int NUM_ACK = 4
)
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // handshake
   input wire logic slow,
   input wire logic stop_req,
   output logic [NUM_ACK-1:0] stop_ack
);
   int cnt_q;
   // acks only while the request stands, all drop with it
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst || !stop_req)
      begin
         cnt_q <= 0;
         stop_ack <= '0;
      end
      else
      begin
         cnt_q <= cnt_q + 1;
         for (int i = 0; i < NUM_ACK; i++)
            stop_ack[i] <= cnt_q >= (slow ? 6 : 1) + i;
      end
   end
endmodule // pms_ack_model

// ===== test/pms_top_checker.sv
`timescale 1ns/10ps
module pms_chk
   import pms_pkg::*;
#(
   parameter int NUM_ACK = 4
)
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // watched ports
   input wire logic wait_instr,
   input wire logic por_option_bit,
   input wire logic [NUM_ACK-1:0] stop_ack,
   input wire logic stop_req,
   input wire logic core_clk_gate,
   input wire logic bus_clk_gate,
   input wire logic freq_limit,
   input wire logic stop_regulation,
   input wire logic logic_low_volt,
   input wire logic logic_power_off,
   input wire logic ram_power_off,
   input wire logic osc_disable,
   input wire logic por_enable,
   input wire logic io_hold,
   input pms_pkg::pms_mode_e power_mode
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // exit steps: bus ungates first, core follows
   sequence s_bus_on; $fell(bus_clk_gate); endsequence
   sequence s_core_on; ##[1:6] $fell(core_clk_gate); endsequence
   property p_order; s_bus_on |-> s_core_on; endproperty
   property p_io; io_hold; endproperty
   property p_ack; $rose(bus_clk_gate) |-> $past(&stop_ack) && core_clk_gate; endproperty
   property p_core; $rose(core_clk_gate) |-> $past(wait_instr); endproperty
   property p_wait; power_mode == PMS_WAIT |-> !bus_clk_gate && !stop_req; endproperty
   property p_reg; stop_regulation == (power_mode >= PMS_VERY_LOW_POWER_RUN); endproperty
   property p_freq;
      freq_limit == (power_mode inside {PMS_VERY_LOW_POWER_RUN, PMS_VERY_LOW_POWER_WAIT, PMS_VERY_LOW_POWER_STOP});
   endproperty
   property p_por; por_enable == (!osc_disable || por_option_bit); endproperty
   property p_llv; logic_low_volt |-> power_mode == PMS_LLS; endproperty
   property p_lpo; logic_power_off |-> power_mode >= PMS_LEAKAGE_STOP_RAM_KEPT; endproperty
   property p_ram; ram_power_off |-> power_mode >= PMS_LEAKAGE_STOP_RAM_OFF; endproperty
   a_order: assert property (p_order) else $error("core ungated late");
   a_io: assert property (p_io) else $error("io hold dropped");
   a_ack: assert property (p_ack) else $error("bus gated early");
   a_core: assert property (p_core) else $error("core gated unasked");
   a_wait: assert property (p_wait) else $error("wait gates bus");
   a_reg: assert property (p_reg) else $error("regulation wrong");
   a_freq: assert property (p_freq) else $error("freq limit wrong");
   a_por: assert property (p_por) else $error("por enable wrong");
   a_llv: assert property (p_llv) else $error("low volt wrong");
   a_lpo: assert property (p_lpo) else $error("logic off wrong");
   a_ram: assert property (p_ram) else $error("ram off wrong");
endmodule // pms_chk

bind pms_top pms_chk #(.NUM_ACK(NUM_ACK)) i_pms_chk (.clk, .sys_rst, .wait_instr,
   .por_option_bit, .stop_ack, .stop_req, .core_clk_gate, .bus_clk_gate, .freq_limit,
   .stop_regulation, .logic_low_volt, .logic_power_off, .ram_power_off, .osc_disable,
   .por_enable, .io_hold, .power_mode);

// ===== test/testbench.sv
`timescale 1ns/10ps
module testbench;
   import pms_pkg::*;
   logic clk, sys_rst, wait_instr, sleep_deep, por_option_bit, wake_event, slow;
   logic allow_vlp, allow_lls, allow_vlls, stop_req, core_clk_gate, bus_clk_gate;
   logic freq_limit, stop_regulation, logic_low_volt, logic_power_off;
   logic ram_power_off, osc_disable, por_enable, io_hold;
   logic [1:0] run_mode_select, vlls_level;
   logic [2:0] stop_mode_select;
   logic [3:0] stop_ack;
   pms_mode_e power_mode;
   int bad_count, checks_done;
   // design and peripheral model
   pms_top #(.NUM_ACK(4)) i_pms_top (.clk, .sys_rst, .clk_en(1'h1), .wait_instr,
      .sleep_deep, .run_mode_select, .stop_mode_select, .vlls_level, .por_option_bit,
      .allow_vlp, .allow_lls, .allow_vlls, .wake_event, .stop_ack, .stop_req,
      .core_clk_gate, .bus_clk_gate, .freq_limit, .stop_regulation, .logic_low_volt,
      .logic_power_off, .ram_power_off, .osc_disable, .por_enable, .io_hold, .power_mode);
   pms_ack_model i_pms_ack_model (.clk, .sys_rst, .slow, .stop_req, .stop_ack);
   initial
   begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   task automatic chk(string n, logic [3:0] e, logic [3:0] s);
      checks_done++;
      if (s !== e)
      begin
         bad_count++;
         $display("unexpected %s expected %0h seen %0h", n, e, s);
      end
   endtask
   // bounded wait for core (0) or bus (1) gate to reach a level
   task automatic gate_wait(bit w, logic v);
      repeat (60) if ((w ? bus_clk_gate : core_clk_gate) !== v) @(negedge clk);
   endtask
   task automatic to_mode(pms_mode_e m);
      repeat (60) if (power_mode !== m) @(negedge clk);
   endtask
   // wait instruction, then check mode and gating
   task automatic nap(logic deep, pms_mode_e m);
      sleep_deep = deep;
      wait_instr = 1'h1;
      gate_wait(0, 1'h1);
      wait_instr = 1'h0;
      chk("mode", m, power_mode);
      if (deep)
         gate_wait(1, 1'h1);
      repeat (3) @(negedge clk);
      chk("bus", {deep, deep}, {bus_clk_gate, stop_req});
   endtask
   task automatic rouse(pms_mode_e m);
      wake_event = 1'h1;
      gate_wait(0, 1'h0);
      wake_event = 1'h0;
      chk("bus", 1'h0, bus_clk_gate);
      to_mode(m);
      chk("mode", m, power_mode);
   endtask
   task automatic t_reset;
      chk("mode", PMS_RUN, power_mode);
      chk("gates", 4'h0, {core_clk_gate, bus_clk_gate, stop_regulation, freq_limit});
      chk("io", 4'h3, {io_hold, por_enable});
      $display("test reset done");
   endtask
   // disallowed and reserved selections must be ignored
   task automatic t_refuse;
      sleep_deep = 1'h1;
      stop_mode_select = 3'h3;
      wait_instr = 1'h1;
      repeat (8) @(negedge clk);
      allow_vlls = 1'h1;
      stop_mode_select = 3'h4;
      vlls_level = 2'h2;
      repeat (8) @(negedge clk);
      run_mode_select = 2'h2;
      repeat (8) @(negedge clk);
      wait_instr = 1'h0;
      run_mode_select = 2'h0;
      chk("mode", PMS_RUN, power_mode);
      chk("core", 1'h0, core_clk_gate);
      $display("test refuse done");
   endtask
   task automatic t_basic;
      stop_mode_select = 3'h0;
      nap(1'h0, PMS_WAIT);
      rouse(PMS_RUN);
      slow = 1'h1;
      nap(1'h1, PMS_STOP);
      chk("reg", 1'h0, stop_regulation);
      rouse(PMS_RUN);
      $display("test basic done");
   endtask
   task automatic t_leak;
      logic [3:0] k;
      allow_lls = 1'h1;
      for (k = 4'h6; k < 4'hA; k++)
      begin
         stop_mode_select = (k == 4'h6) ? 3'h3 : 3'h4;
         vlls_level = {k == 4'h7, k != 4'h9};
         por_option_bit = ~k[0];
         nap(1'h1, pms_mode_e'(k));
         chk("power", {k == 4'h6, k > 4'h6, k > 4'h7, k == 4'h9},
            {logic_low_volt, logic_power_off, ram_power_off, osc_disable});
         chk("por", k != 4'h9, por_enable);
         chk("reg", 1'h1, stop_regulation);
         rouse(PMS_RUN);
      end
      $display("test leak done");
   endtask
   task automatic t_vlp;
      allow_vlp = 1'h1;
      run_mode_select = 2'h2;
      to_mode(PMS_VERY_LOW_POWER_RUN);
      chk("mode", PMS_VERY_LOW_POWER_RUN, power_mode);
      chk("limit", 4'h3, {freq_limit, stop_regulation});
      nap(1'h0, PMS_VERY_LOW_POWER_WAIT);
      chk("limit", 1'h1, freq_limit);
      rouse(PMS_VERY_LOW_POWER_RUN);
      stop_mode_select = 3'h2;
      nap(1'h1, PMS_VERY_LOW_POWER_STOP);
      rouse(PMS_VERY_LOW_POWER_RUN);
      run_mode_select = 2'h0;
      to_mode(PMS_RUN);
      chk("mode", PMS_RUN, power_mode);
      $display("test vlp done");
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog: tests need well under a thousand cycles
   initial
   begin
      #250000;
      bad_count++;
      report_and_stop;
   end
   initial
   begin
      {wait_instr, sleep_deep, por_option_bit, wake_event, slow} = '0;
      {allow_vlp, allow_lls, allow_vlls} = '0;
      run_mode_select = 2'h0;
      stop_mode_select = 3'h0;
      vlls_level = 2'h3;
      sys_rst = 1'h1;
      repeat (16) @(negedge clk);
      sys_rst = 1'h0;
      t_reset;
      t_refuse;
      t_basic;
      t_leak;
      t_vlp;
      report_and_stop;
   end
endmodule // testbench
